// ### hw/xcvr_cfg_pkg.sv
// Constants, field layouts and carrier types of the transceiver register bank
package xcvr_cfg_pkg;
	// Timing
	localparam int CLK_MHZ          = 25;
	localparam int SCAN_PERIOD_US   = 150;
	localparam int SCAN_CYCLES      = SCAN_PERIOD_US * CLK_MHZ;
	localparam int SYNC_TOUT_US     = 100;
	localparam int SYNC_TOUT_CYCLES = SYNC_TOUT_US * CLK_MHZ;
	localparam int CNT_W            = 12;
	localparam logic [CNT_W-1:0] SCAN_LAST = CNT_W'(SCAN_CYCLES - 1);
	localparam logic [CNT_W-1:0] TOUT_LIM  = CNT_W'(SYNC_TOUT_CYCLES);
	// Register addresses
	localparam logic [5:0] ADDR_GEN_CFG1  = 6'h01;
	localparam logic [5:0] ADDR_CHAN_CTRL = 6'h02;
	localparam logic [5:0] ADDR_NO_OP     = 6'h03;
	localparam logic [5:0] ADDR_FAULT1    = 6'h04;
	// Reset values and writable masks
	localparam logic [15:0] GEN_CFG1_RST  = 16'h8000;
	localparam logic [15:0] GEN_CFG1_WMSK = 16'hffdf;
	localparam logic [15:0] CHAN_CTRL_RST = 16'h0442;
	localparam logic [15:0] CHAN_CTRL_WMSK = 16'h077b;
	// General configuration fields
	localparam int G_MUX_DIS = 14;
	localparam int G_BUF2    = 13;
	localparam int G_TRIG2_H = 12;
	localparam int G_TRIG2_L = 11;
	localparam int G_METH2   = 10;
	localparam int G_BUF1    = 9;
	localparam int G_TRIG1_H = 8;
	localparam int G_TRIG1_L = 7;
	localparam int G_METH1   = 6;
	localparam int G_CLK_H   = 4;
	localparam int G_CLK_L   = 3;
	localparam int G_IDG     = 2;
	localparam int G_CRC     = 1;
	localparam int G_REG_LVL = 0;
	// Channel control fields
	localparam int C_REG_EN  = 10;
	localparam int C_TRIG2_H = 9;
	localparam int C_TRIG2_L = 8;
	localparam int C_ALLOW2  = 6;
	localparam int C_EN2     = 5;
	localparam int C_TRIG1_H = 4;
	localparam int C_TRIG1_L = 3;
	localparam int C_ALLOW1  = 1;
	localparam int C_EN1     = 0;
	// Fault status fields
	localparam int F_XDONE = 15;
	localparam int F_XABT  = 14;
	localparam int F_XRUN  = 13;
	localparam int F_SER   = 12;
	localparam int F_OTP   = 11;
	localparam int F_UV    = 10;
	localparam int F_OV    = 9;
	localparam int F_UVL   = 8;
	localparam int F_TOUT2 = 7;
	localparam int F_BUF2  = 6;
	localparam int F_SLOW2 = 5;
	localparam int F_LOW2  = 4;
	localparam int F_TOUT1 = 3;
	localparam int F_BUF1  = 2;
	localparam int F_SLOW1 = 1;
	localparam int F_LOW1  = 0;
	localparam logic [15:0] FAULT_RC_MSK = 16'hd4ff;
	localparam logic [15:0] FAULT_LATCH  = 16'hd5ff;
	// Global status bits on the no-operation read
	localparam int GS_PARITY = 0;
	localparam int GS_FAULT  = 1;
	localparam int GS_LOCKED = 2;
	// Sync request codes and payload lengths
	localparam logic [1:0] SREQ_SHORT = 2'h1;
	localparam logic [1:0] SREQ_LONG  = 2'h2;
	localparam logic [4:0] PAYLOAD_A  = 5'h0a;
	localparam logic [4:0] PAYLOAD_B  = 5'h10;

	typedef enum logic [1:0] {
		TRIG_PIN    = 2'h0,
		TRIG_SERIAL = 2'h1,
		TRIG_AUTO   = 2'h2,
		TRIG_PIN_B  = 2'h3
	} trig_src_t;

	typedef enum logic [1:0] {
		CLKREF_NONE = 2'h0,
		CLKREF_1MHZ = 2'h1,
		CLKREF_4MHZ = 2'h2
	} clk_ref_t;

	typedef struct packed {
		logic       write;
		logic [5:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic      buffer_length;
		trig_src_t trigger;
		logic      pulse_width;
		logic      enable;
		logic      sync_allow;
	} chan_cfg_t;
endpackage

// ### hw/sensor_transceiver_config_regs.sv
// Configuration and fault status register bank with link-side register port
// Functional notes
// - Config-once register locks after end-programming
// - Parity scan every 150 us sets fault
// - Clear-on-read latched bits except deep-UV; real-time bits live
// - Bit 14 disables serial address multiplexing
// - Buffer-length select; automatic forces buffer length
// - Two-bit trigger source per channel
// - Sync method only with buffer length
// - Clock input select: none, 1MHz, 4MHz
// - Id/G-bit use only for 10/16-bit payloads
// - Check-bit source: sensor or computed
// - Regulator enable, resets to one
// - Serial sync request acts once per write
// - Sync allow bit, resets to one
// - Channel enable bit, resets to zero
// - No-op write changes nothing, reads status
// - Cross-coupling done/abort latched, running live
// - Serial fault on framing or address errors
// - Undervoltage latched, overvoltage live, deep-UV confirm
// - Sync pin held beyond 100 us
// - Buffer write while pending sets fault
// - Slow sync and low-level flags latch
`timescale 1ns/1ps
module sensor_transceiver_config_regs (
	input  wire logic                     clock_in,
	input  wire logic                     rst_in,
	input  wire logic                     link_clk_in,
	input  wire logic                     req_valid_in,
	input  wire logic                     req_write_in,
	input  wire logic [5:0]               req_addr_in,
	input  wire logic [15:0]              req_wdata_in,
	output logic                          req_ready_out,
	output logic                          resp_valid_out,
	output logic [15:0]                   resp_rdata_out,
	input  wire logic                     end_programming_in,
	input  wire logic                     crc_error_in,
	input  wire logic                     clk_count_error_in,
	input  wire logic                     read_order_error_in,
	input  wire logic [1:0]               buffer_write_in,
	input  wire logic [1:0]               buffer_pending_in,
	input  wire logic [4:0]               payload_bits_in,
	input  wire logic                     xct_done_in,
	input  wire logic                     xct_abort_in,
	input  wire logic                     xct_running_in,
	input  wire logic                     otp_error_in,
	input  wire logic                     supply_undervoltage_in,
	input  wire logic                     supply_overvoltage_in,
	input  wire logic                     supply_deep_undervoltage_in,
	input  wire logic [1:0]               sync_slow_in,
	input  wire logic [1:0]               sync_low_in,
	input  wire logic [1:0]               sync_pin_in,
	output logic                          address_mux_disable_out,
	output xcvr_cfg_pkg::chan_cfg_t [1:0] chan_cfg_out,
	output xcvr_cfg_pkg::clk_ref_t        clock_ref_out,
	output logic                          sid_gbit_active_out,
	output logic                          crc_source_select_out,
	output logic                          regulator_level_out,
	output logic                          regulator_on_out,
	output logic [1:0]                    sync_req_out,
	output logic [1:0]                    sync_long_out,
	output logic [1:0]                    sync_use_buffer_out,
	output logic                          config_locked_out,
	output logic                          global_fault_out
);
	// Odd parity over a whole word
	function automatic logic odd_ok(input logic [15:0] w);
		odd_ok = ^w;
	endfunction

	// Effective per-channel configuration
	function automatic xcvr_cfg_pkg::chan_cfg_t chan_decode(
		input logic [15:0] g,
		input logic [15:0] c,
		input logic        ch
	);
		xcvr_cfg_pkg::chan_cfg_t r;
		r.trigger = ch ? xcvr_cfg_pkg::trig_src_t'(g[xcvr_cfg_pkg::G_TRIG2_H:xcvr_cfg_pkg::G_TRIG2_L])
		               : xcvr_cfg_pkg::trig_src_t'(g[xcvr_cfg_pkg::G_TRIG1_H:xcvr_cfg_pkg::G_TRIG1_L]);
		r.buffer_length = (ch ? g[xcvr_cfg_pkg::G_BUF2] : g[xcvr_cfg_pkg::G_BUF1])
		                  | (r.trigger == xcvr_cfg_pkg::TRIG_AUTO);
		r.pulse_width = r.buffer_length
		                & (ch ? g[xcvr_cfg_pkg::G_METH2] : g[xcvr_cfg_pkg::G_METH1]);
		r.enable     = ch ? c[xcvr_cfg_pkg::C_EN2] : c[xcvr_cfg_pkg::C_EN1];
		r.sync_allow = ch ? c[xcvr_cfg_pkg::C_ALLOW2] : c[xcvr_cfg_pkg::C_ALLOW1];
		chan_decode = r;
	endfunction

	// Link domain
	xcvr_cfg_pkg::reg_req_t req_ff;
	logic        busy_ff;
	logic        req_tgl_ff;
	logic        ack_s1_ff;
	logic        ack_s2_ff;
	logic        ack_s3_ff;
	logic        resp_valid_ff;
	logic [15:0] resp_rdata_ff;
	logic        ack_edge;
	// Core domain
	logic        req_s1_ff;
	logic        req_s2_ff;
	logic        req_s3_ff;
	logic        ack_tgl_ff;
	logic [15:0] rdata_ff;
	logic        acc;
	logic [12:0] async_s1_ff;
	logic [12:0] async_s2_ff;
	logic [15:0] gen_cfg_ff;
	logic [15:0] chan_ctrl_ff;
	logic        locked_ff;
	logic [15:0] fault_ff;
	logic [15:0] nxt_fault;
	logic [15:0] fault_set;
	logic [15:0] fault_clr;
	logic [15:0] live_rt;
	logic [15:0] rd_mux;
	logic [xcvr_cfg_pkg::CNT_W-1:0] scan_cnt_ff;
	logic        scan_tick;
	logic        parity_fault_ff;
	logic [xcvr_cfg_pkg::CNT_W-1:0] tout_cnt_ff [2];
	logic [1:0]  tout_evt;
	logic [1:0]  sync_req_ff;
	logic [1:0]  sync_long_ff;
	logic [1:0]  sync_buf_ff;
	logic        reg_on_ff;
	logic        idg_ff;
	logic        wr_gen;
	logic        wr_chan;
	logic        rd_fault;
	logic        bad_addr;
	logic        pin_mode [2];

	// Link side accepts one request at a time; word held until the core answers
	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_ff     <= '0;
			req_tgl_ff <= 1'b0;
			busy_ff    <= 1'b0;
		end else if (req_valid_in && !busy_ff) begin
			req_ff     <= '{write: req_write_in, addr: req_addr_in, wdata: req_wdata_in};
			req_tgl_ff <= ~req_tgl_ff;
			busy_ff    <= 1'b1;
		end else if (ack_edge) begin
			busy_ff <= 1'b0;
		end
	end

	// Answer toggle from the core, synchronised into the link clock
	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
		end else begin
			ack_s1_ff <= ack_tgl_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
		end
	end

	assign ack_edge      = ack_s2_ff ^ ack_s3_ff;
	assign req_ready_out = !busy_ff;

	// Read data is stable in the core once its toggle is seen here
	always_ff @(posedge link_clk_in or posedge rst_in) begin
		if (rst_in) begin
			resp_valid_ff <= 1'b0;
			resp_rdata_ff <= '0;
		end else begin
			resp_valid_ff <= ack_edge;
			if (ack_edge) begin
				resp_rdata_ff <= rdata_ff;
			end
		end
	end

	assign resp_valid_out = resp_valid_ff;
	assign resp_rdata_out = resp_rdata_ff;

	// Request toggle into the core clock
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
		end else begin
			req_s1_ff <= req_tgl_ff;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end

	assign acc = req_s2_ff ^ req_s3_ff;

	// Analog and pin levels pass two flops before use
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			async_s1_ff <= '0;
			async_s2_ff <= '0;
		end else begin
			async_s1_ff <= {xct_done_in, xct_abort_in, xct_running_in, otp_error_in,
			                supply_undervoltage_in, supply_overvoltage_in, supply_deep_undervoltage_in, sync_slow_in,
			                sync_low_in, sync_pin_in};
			async_s2_ff <= async_s1_ff;
		end
	end

	// Access decode; the link word is stable while the handshake is open
	always_comb begin
		wr_gen   = acc && req_ff.write && (req_ff.addr == xcvr_cfg_pkg::ADDR_GEN_CFG1)
		           && !locked_ff;
		wr_chan  = acc && req_ff.write && (req_ff.addr == xcvr_cfg_pkg::ADDR_CHAN_CTRL);
		rd_fault = acc && !req_ff.write && (req_ff.addr == xcvr_cfg_pkg::ADDR_FAULT1);
		bad_addr = acc && !(req_ff.addr inside {xcvr_cfg_pkg::ADDR_GEN_CFG1,
		           xcvr_cfg_pkg::ADDR_CHAN_CTRL, xcvr_cfg_pkg::ADDR_NO_OP,
		           xcvr_cfg_pkg::ADDR_FAULT1});
	end

	// Programming lock; only reset reopens it
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			locked_ff <= 1'b0;
		end else if (end_programming_in) begin
			locked_ff <= 1'b1;
		end
	end

	// Config-once register; no-op writes fall through untouched
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gen_cfg_ff <= xcvr_cfg_pkg::GEN_CFG1_RST;
		end else if (wr_gen) begin
			gen_cfg_ff <= req_ff.wdata & xcvr_cfg_pkg::GEN_CFG1_WMSK;
		end
	end

	// Channel control; enables, allows and regulator stored here
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			chan_ctrl_ff <= xcvr_cfg_pkg::CHAN_CTRL_RST;
		end else if (wr_chan) begin
			chan_ctrl_ff <= req_ff.wdata & xcvr_cfg_pkg::CHAN_CTRL_WMSK;
		end
	end

	// Parity scan: a bad word is seen at most one period late
	assign scan_tick = (scan_cnt_ff == xcvr_cfg_pkg::SCAN_LAST);
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			scan_cnt_ff     <= '0;
			parity_fault_ff <= 1'b0;
		end else begin
			scan_cnt_ff <= scan_tick ? '0 : scan_cnt_ff + 1'b1;
			if (scan_tick) begin
				parity_fault_ff <= !odd_ok(gen_cfg_ff);
			end
		end
	end

	// Pin-driven sync pulse length watchdog per channel
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_mode[i] = chan_cfg_out[i].enable
			              && ((chan_cfg_out[i].trigger == xcvr_cfg_pkg::TRIG_PIN)
			              || (chan_cfg_out[i].trigger == xcvr_cfg_pkg::TRIG_PIN_B));
			tout_evt[i] = pin_mode[i] && async_s2_ff[i]
			              && (tout_cnt_ff[i] == xcvr_cfg_pkg::TOUT_LIM);
		end
	end

	// Counter saturates so a stuck pin keeps the flag raised
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tout_cnt_ff[0] <= '0;
			tout_cnt_ff[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!(pin_mode[i] && async_s2_ff[i])) begin
					tout_cnt_ff[i] <= '0;
				end else if (tout_cnt_ff[i] != xcvr_cfg_pkg::TOUT_LIM) begin
					tout_cnt_ff[i] <= tout_cnt_ff[i] + 1'b1;
				end
			end
		end
	end

	// Fault events; set beats any clear in the same cycle
	always_comb begin
		fault_set = '0;
		fault_set[xcvr_cfg_pkg::F_XDONE] = async_s2_ff[12];
		fault_set[xcvr_cfg_pkg::F_XABT]  = async_s2_ff[11];
		fault_set[xcvr_cfg_pkg::F_SER]   = crc_error_in | clk_count_error_in
		                                   | read_order_error_in | bad_addr;
		fault_set[xcvr_cfg_pkg::F_UV]    = async_s2_ff[8];
		fault_set[xcvr_cfg_pkg::F_UVL]   = async_s2_ff[6];
		fault_set[xcvr_cfg_pkg::F_TOUT2] = tout_evt[1];
		fault_set[xcvr_cfg_pkg::F_BUF2]  = buffer_write_in[1] & buffer_pending_in[1];
		fault_set[xcvr_cfg_pkg::F_SLOW2] = async_s2_ff[5];
		fault_set[xcvr_cfg_pkg::F_LOW2]  = async_s2_ff[3];
		fault_set[xcvr_cfg_pkg::F_TOUT1] = tout_evt[0];
		fault_set[xcvr_cfg_pkg::F_BUF1]  = buffer_write_in[0] & buffer_pending_in[0];
		fault_set[xcvr_cfg_pkg::F_SLOW1] = async_s2_ff[4];
		fault_set[xcvr_cfg_pkg::F_LOW1]  = async_s2_ff[2];
		fault_clr = rd_fault ? xcvr_cfg_pkg::FAULT_RC_MSK : '0;
		// Deep undervoltage clears only on a regulator-off confirmation
		fault_clr[xcvr_cfg_pkg::F_UVL] = wr_chan && !req_ff.wdata[xcvr_cfg_pkg::C_REG_EN];
		nxt_fault = ((fault_ff & ~fault_clr) | fault_set) & xcvr_cfg_pkg::FAULT_LATCH;
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			fault_ff <= '0;
		end else begin
			fault_ff <= nxt_fault;
		end
	end

	// Read mux; real-time bits bypass the latches
	always_comb begin
		live_rt = '0;
		live_rt[xcvr_cfg_pkg::F_XRUN] = async_s2_ff[10];
		live_rt[xcvr_cfg_pkg::F_OTP]  = async_s2_ff[9];
		live_rt[xcvr_cfg_pkg::F_OV]   = async_s2_ff[7];
		rd_mux = '0;
		case (req_ff.addr)
			xcvr_cfg_pkg::ADDR_GEN_CFG1: rd_mux = gen_cfg_ff;
			xcvr_cfg_pkg::ADDR_CHAN_CTRL: rd_mux = chan_ctrl_ff;
			xcvr_cfg_pkg::ADDR_NO_OP: begin
				rd_mux[xcvr_cfg_pkg::GS_PARITY] = parity_fault_ff;
				rd_mux[xcvr_cfg_pkg::GS_FAULT]  = |fault_ff;
				rd_mux[xcvr_cfg_pkg::GS_LOCKED] = locked_ff;
			end
			xcvr_cfg_pkg::ADDR_FAULT1: rd_mux = fault_ff | live_rt;
			default: rd_mux = '0;
		endcase
	end

	// Answer word and toggle back to the link
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_ff   <= '0;
			ack_tgl_ff <= 1'b0;
		end else if (acc) begin
			rdata_ff   <= req_ff.write ? '0 : rd_mux;
			ack_tgl_ff <= ~ack_tgl_ff;
		end
	end

	// Serial sync requests fire once, only on the write that carries them
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sync_req_ff  <= '0;
			sync_long_ff <= '0;
			sync_buf_ff  <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				logic [1:0] code;
				logic       fire;
				xcvr_cfg_pkg::chan_cfg_t nc;
				nc   = chan_decode(gen_cfg_ff, req_ff.wdata, i[0]);
				code = i[0] ? req_ff.wdata[xcvr_cfg_pkg::C_TRIG2_H:xcvr_cfg_pkg::C_TRIG2_L]
				            : req_ff.wdata[xcvr_cfg_pkg::C_TRIG1_H:xcvr_cfg_pkg::C_TRIG1_L];
				fire = wr_chan && nc.enable && nc.sync_allow
				       && (nc.trigger == xcvr_cfg_pkg::TRIG_SERIAL)
				       && (code == xcvr_cfg_pkg::SREQ_SHORT
				       || code == xcvr_cfg_pkg::SREQ_LONG);
				sync_req_ff[i]  <= fire;
				sync_long_ff[i] <= fire && !nc.buffer_length
				                   && (code == xcvr_cfg_pkg::SREQ_LONG);
				sync_buf_ff[i]  <= fire && nc.buffer_length;
			end
		end
	end

	// Registered derived controls; regulator drops on deep undervoltage
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			reg_on_ff <= 1'b0;
			idg_ff    <= 1'b0;
		end else begin
			reg_on_ff <= chan_ctrl_ff[xcvr_cfg_pkg::C_REG_EN]
			             && !fault_ff[xcvr_cfg_pkg::F_UVL];
			idg_ff    <= gen_cfg_ff[xcvr_cfg_pkg::G_IDG]
			             && (payload_bits_in == xcvr_cfg_pkg::PAYLOAD_A
			             || payload_bits_in == xcvr_cfg_pkg::PAYLOAD_B);
		end
	end

	// Outputs from the stored words and from the registered controls, sync requests and flags
	assign address_mux_disable_out = gen_cfg_ff[xcvr_cfg_pkg::G_MUX_DIS];
	assign chan_cfg_out      = {chan_decode(gen_cfg_ff, chan_ctrl_ff, 1'b1),
	                            chan_decode(gen_cfg_ff, chan_ctrl_ff, 1'b0)};
	assign clock_ref_out     = (gen_cfg_ff[xcvr_cfg_pkg::G_CLK_H:xcvr_cfg_pkg::G_CLK_L]
	                           == 2'h3) ? xcvr_cfg_pkg::CLKREF_NONE
	                           : xcvr_cfg_pkg::clk_ref_t'(gen_cfg_ff[xcvr_cfg_pkg::G_CLK_H:
	                             xcvr_cfg_pkg::G_CLK_L]);
	assign sid_gbit_active_out   = idg_ff;
	assign crc_source_select_out = gen_cfg_ff[xcvr_cfg_pkg::G_CRC];
	assign regulator_level_out   = gen_cfg_ff[xcvr_cfg_pkg::G_REG_LVL];
	assign regulator_on_out      = reg_on_ff;
	assign sync_req_out          = sync_req_ff;
	assign sync_long_out         = sync_long_ff;
	assign sync_use_buffer_out   = sync_buf_ff;
	assign config_locked_out     = locked_ff;
	assign global_fault_out      = parity_fault_ff;

	// Checks
	a_lock_holds: assert property (@(posedge clock_in) disable iff (rst_in)
		locked_ff && $past(locked_ff) |-> $stable(gen_cfg_ff))
		else $error("config word changed after lock");
	a_locked_drop: assert property (@(posedge clock_in) disable iff (rst_in)
		acc && req_ff.write && req_ff.addr == xcvr_cfg_pkg::ADDR_GEN_CFG1 && locked_ff
		|=> $stable(gen_cfg_ff) && $stable(chan_ctrl_ff))
		else $error("locked write altered state");
	a_parity_flag: assert property (@(posedge clock_in) disable iff (rst_in)
		scan_tick |=> global_fault_out == !odd_ok($past(gen_cfg_ff)))
		else $error("parity scan result wrong");
	a_parity_period: assert property (@(posedge clock_in) disable iff (rst_in)
		scan_tick |=> !scan_tick [*8])
		else $error("parity scan too frequent");
	a_read_clears: assert property (@(posedge clock_in) disable iff (rst_in)
		rd_fault && !fault_set[xcvr_cfg_pkg::F_XDONE] |=> !fault_ff[xcvr_cfg_pkg::F_XDONE])
		else $error("latched flag not cleared by read");
	a_set_wins: assert property (@(posedge clock_in) disable iff (rst_in)
		fault_set[xcvr_cfg_pkg::F_LOW1] |=> fault_ff[xcvr_cfg_pkg::F_LOW1])
		else $error("event lost");
	a_noop_stable: assert property (@(posedge clock_in) disable iff (rst_in)
		acc && req_ff.write && req_ff.addr == xcvr_cfg_pkg::ADDR_NO_OP
		|=> $stable(gen_cfg_ff) && $stable(chan_ctrl_ff) && $stable(locked_ff))
		else $error("no-op write changed state");
	a_sync_gate: assert property (@(posedge clock_in) disable iff (rst_in)
		sync_req_out[0] |-> $past(wr_chan) && chan_cfg_out[0].enable
		&& chan_cfg_out[0].sync_allow)
		else $error("sync request without enabled write");
	a_sync_once: assert property (@(posedge clock_in) disable iff (rst_in)
		sync_req_out[0] && !wr_chan |=> !sync_req_out[0])
		else $error("sync request repeated");
	a_tout_flag: assert property (@(posedge clock_in) disable iff (rst_in)
		tout_evt[0] |=> fault_ff[xcvr_cfg_pkg::F_TOUT1])
		else $error("sync timeout not flagged");
	a_uvl_confirm: assert property (@(posedge clock_in) disable iff (rst_in)
		fault_ff[xcvr_cfg_pkg::F_UVL] && !fault_set[xcvr_cfg_pkg::F_UVL]
		&& !fault_clr[xcvr_cfg_pkg::F_UVL] |=> fault_ff[xcvr_cfg_pkg::F_UVL]
		##1 !regulator_on_out)
		else $error("deep undervoltage cleared without confirm");
	a_buf_fault: assert property (@(posedge clock_in) disable iff (rst_in)
		buffer_write_in[1] && buffer_pending_in[1] |=> fault_ff[xcvr_cfg_pkg::F_BUF2])
		else $error("buffer fault missed");
	a_bad_addr: assert property (@(posedge clock_in) disable iff (rst_in)
		bad_addr |=> fault_ff[xcvr_cfg_pkg::F_SER])
		else $error("invalid address not flagged");
	a_auto_buffer: assert property (@(posedge clock_in) disable iff (rst_in)
		chan_cfg_out[1].trigger == xcvr_cfg_pkg::TRIG_AUTO |-> chan_cfg_out[1].buffer_length)
		else $error("automatic mode without buffer length");
endmodule // sensor_transceiver_config_regs

// ### verification/host_link_model.sv
// Host side model driving the register port on the link clock
`timescale 1ns/1ps
module host_link_model (
	input  wire logic        link_clk_in,
	input  wire logic        req_ready_out,
	input  wire logic        resp_valid_out,
	input  wire logic [15:0] resp_rdata_out,
	output logic             req_valid_in,
	output logic             req_write_in,
	output logic [5:0]       req_addr_in,
	output logic [15:0]      req_wdata_in
);
	initial {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = '0;
	// One request at a time; data inverted once released so stale values never match
	task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge link_clk_in);
		{req_valid_in, req_write_in, req_addr_in, req_wdata_in} <= {1'b1, w, a, d};
		do @(negedge link_clk_in); while (req_ready_out !== 1'b1);
		@(posedge link_clk_in);
		req_valid_in <= 1'b0;
		req_wdata_in <= ~d;
		// A lost answer hangs here and is caught by the bench watchdog
		do @(negedge link_clk_in); while (resp_valid_out !== 1'b1);
		q = resp_rdata_out;
	endtask
endmodule // host_link_model

// ### verification/sensor_transceiver_config_regs_bench.sv
// Self-checking bench for the transceiver register bank
`timescale 1ns/1ps
module sensor_transceiver_config_regs_bench;
	logic clock_in = 0, rst_in = 1, link_clk_in = 0, end_programming_in = 0, crc_error_in = 0;
	logic clk_count_error_in = 0, read_order_error_in = 0, xct_done_in = 0, xct_abort_in = 0;
	logic xct_running_in = 0, otp_error_in = 0, supply_undervoltage_in = 0, supply_overvoltage_in = 0, supply_deep_undervoltage_in = 0;
	logic [1:0] buffer_write_in = 0, buffer_pending_in = 0, sync_slow_in = 0, sync_low_in = 0;
	logic [1:0] sync_pin_in = 0, sync_req_out, sync_long_out, sync_use_buffer_out;
	logic [4:0] payload_bits_in = 5'h0a;
	logic req_valid_in, req_write_in, req_ready_out, resp_valid_out, address_mux_disable_out;
	logic sid_gbit_active_out, crc_source_select_out, regulator_level_out, regulator_on_out;
	logic config_locked_out, global_fault_out;
	logic [5:0] req_addr_in;
	logic [15:0] req_wdata_in, resp_rdata_out, q, d;
	xcvr_cfg_pkg::chan_cfg_t [1:0] chan_cfg_out;
	xcvr_cfg_pkg::clk_ref_t clock_ref_out;
	int error_cnt = 0, tests_run = 0, sync_cnt = 0, n;
	// Rows: write, address, write data, expected answer
	localparam logic [38:0] rows [10] = '{{1'b0, 6'h01, 16'h0, 16'h8000},
		{1'b0, 6'h02, 16'h0, 16'h0442}, {1'b1, 6'h01, 16'h4005, 16'h0},
		{1'b0, 6'h01, 16'h0, 16'h4005}, {1'b1, 6'h02, 16'hffff, 16'h0},
		{1'b0, 6'h02, 16'h0, 16'h077b}, {1'b0, 6'h05, 16'h0, 16'h0},
		{1'b0, 6'h03, 16'h0, 16'h0002}, {1'b0, 6'h04, 16'h0, 16'h1000},
		{1'b0, 6'h04, 16'h0, 16'h0}};
	sensor_transceiver_config_regs i_dut (.*);
	host_link_model i_host (.*);
	always #20 clock_in = ~clock_in;
	// Offset start keeps the link clock out of phase with the core clock
	initial begin
		#5;
		forever #32 link_clk_in = ~link_clk_in;
	end
	// Weighted count tells short, long and buffer-length pulses apart
	always @(negedge clock_in)
		if (sync_req_out[0] === 1'b1)
			sync_cnt += sync_use_buffer_out[0] ? 256 : (sync_long_out[0] ? 16 : 1);
	task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#500_000;
		error_cnt++;
		summarize;
	end
	initial begin
		repeat (2) @(negedge clock_in);
		rst_in = 0;
		foreach (rows[i]) begin
			i_host.xfer(rows[i][38], rows[i][37:32], rows[i][31:16], q);
			check("row", q, rows[i][15:0]);
		end
		check("gen bits", {address_mux_disable_out, crc_source_select_out, regulator_level_out,
			sid_gbit_active_out}, 16'h000b);
		check("reg on", regulator_on_out, 1);
		@(negedge clock_in) payload_bits_in = 5'h0c;
		repeat (2) @(negedge clock_in);
		check("sid off", sid_gbit_active_out, 0);
		$display("test rows done");
		for (int k = 0; k < 4; k++) begin
			d = 16'(k * 16'h0888) | 16'h0040;
			d[15] = ~^d[14:0];
			i_host.xfer(1, 6'h01, d, q);
			check("trigger", chan_cfg_out[0].trigger, 16'(k));
			check("trigger 2", chan_cfg_out[1].trigger, 16'(k));
			check("buf len", chan_cfg_out[0].buffer_length, 16'(k == 2));
			check("method", chan_cfg_out[0].pulse_width, 16'(k == 2));
			check("clock ref", clock_ref_out, 16'(k % 3));
		end
		i_host.xfer(1, 6'h01, 16'h0080, q);
		n = sync_cnt;
		i_host.xfer(1, 6'h02, 16'h040b, q);
		check("sync", 16'(sync_cnt - n), 1);
		i_host.xfer(1, 6'h02, 16'h040a, q);
		check("sync off", 16'(sync_cnt - n), 1);
		i_host.xfer(1, 6'h02, 16'h0413, q);
		check("sync long", 16'(sync_cnt - n), 17);
		i_host.xfer(1, 6'h01, 16'h8280, q);
		i_host.xfer(1, 6'h02, 16'h0413, q);
		check("sync buffer", 16'(sync_cnt - n), 273);
		$display("test modes done");
		// Latched and live flags raised together, latched ones dropped before reading
		@(negedge clock_in);
		{xct_done_in, xct_abort_in, xct_running_in, crc_error_in, otp_error_in} = '1;
		{supply_undervoltage_in, supply_overvoltage_in, supply_deep_undervoltage_in} = '1;
		{buffer_write_in, buffer_pending_in, sync_slow_in, sync_low_in} = 8'hf6;
		repeat (2) @(negedge clock_in);
		{xct_done_in, xct_abort_in, crc_error_in, supply_undervoltage_in, supply_deep_undervoltage_in} = '0;
		{buffer_write_in, buffer_pending_in, sync_slow_in, sync_low_in} = 8'h00;
		i_host.xfer(0, 6'h04, 0, q);
		check("faults", q, 16'hff56);
		i_host.xfer(0, 6'h04, 0, q);
		check("live", q, 16'h2b00);
		check("reg off", regulator_on_out, 0);
		{xct_running_in, otp_error_in, supply_overvoltage_in} = '0;
		// Regulator-off write confirms deep undervoltage; channel 1 stays on for the pin test
		i_host.xfer(1, 6'h02, 16'h0001, q);
		i_host.xfer(0, 6'h04, 0, q);
		check("confirm", q, 16'h0000);
		$display("test faults done");
		i_host.xfer(1, 6'h01, 16'h0000, q);
		@(negedge clock_in) sync_pin_in = 2'h1;
		repeat (3800) @(negedge clock_in);
		check("parity", global_fault_out, 1);
		i_host.xfer(0, 6'h04, 0, q);
		check("timeout", q, 16'h0008);
		sync_pin_in = 2'h0;
		@(negedge clock_in) end_programming_in = 1;
		@(negedge clock_in) end_programming_in = 0;
		i_host.xfer(1, 6'h01, 16'h8000, q);
		i_host.xfer(0, 6'h01, 0, q);
		check("locked", q, 0);
		check("lock flag", config_locked_out, 1);
		$display("test lock done");
		// Second reset mid-run reopens the lock and restores reset values
		@(negedge clock_in) rst_in = 1;
		repeat (2) @(negedge clock_in);
		rst_in = 0;
		check("reset state", {req_ready_out, config_locked_out}, 16'h0002);
		i_host.xfer(0, 6'h01, 0, q);
		check("reset cfg", q, 16'h8000);
		check("reset reg", regulator_on_out, 1);
		$display("test reset done");
		summarize;
	end
endmodule // sensor_transceiver_config_regs_bench
